// >>> pkg/lco_pkg.sv
// shared constants of the light curtain output and latch control
// assumes a single 125 MHz core clock and a byte-addressed register port
package lco_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned CLK_MHZ = 125;
  // least open time of a valid manual reset, in microseconds
  localparam int unsigned RST_OPEN_US = 250000;
  localparam int unsigned RST_OPEN_CYC = RST_OPEN_US * CLK_MHZ;
  // half period of the indicator flash, in microseconds
  localparam int unsigned FLASH_HALF_US = 250000;
  localparam int unsigned FLASH_CYC = FLASH_HALF_US * CLK_MHZ;
  // longest output turn-off time, in nanoseconds
  localparam int unsigned RESP_TIME_NS = 4000;

  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATE = 4'h4;
  localparam logic [3:0] ADDR_INT_STS = 4'h8;
  localparam logic [3:0] ADDR_INT_MASK = 4'hc;

  localparam int CTRL_LATCH_BIT = 0;
  localparam logic CTRL_LATCH_RST = 1'b0;
  localparam int STATE_ON_BIT = 3;
  localparam int STATE_CLEAR_BIT = 4;

  localparam int NUM_EVT = 4;
  localparam int EVT_BLOCK = 0;
  localparam int EVT_LOCK = 1;
  localparam int EVT_RESET = 2;
  localparam int EVT_RSTFLT = 3;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_RUN = 3'b001,
    ST_BLOCKED = 3'b011,
    ST_WAIT = 3'b010,
    ST_LOCKOUT = 3'b110,
    ST_RSTFLT = 3'b100
  } lco_state_t;
endpackage : lco_pkg

// >>> src/lco_ctrl.sv
// receiver output control: safety outputs, trip/latch, lockout, indicators
// assumes beam, fault, switch and power inputs synchronous to core_clk
//
// What this block does
// RQ1 - blocked beam turns outputs off promptly
// RQ2 - trip mode: outputs return when all clear
// RQ3 - trip mode: no manual reset after block
// RQ4 - latch mode: clear after block waits, aligns flash
// RQ5 - latch mode: on only after valid reset, clear
// RQ6 - critical fault forces lockout, outputs off
// RQ7 - valid reset: open a quarter second, close
// RQ8 - lockout flashes the red indicator
// RQ9 - blocked: red steady, green off, aligns per beam
// RQ10 - clear and on: green and aligns on
// RQ11 - latched and clear: red on, aligns flash
// RQ12 - latch power-up waits for manual reset; latch_q resets to trip, so ST_INIT after sys_rst goes to ST_BLOCKED
// RQ13 - supply loss drops outputs at once
// RQ14 - where a manual reset is demanded
// RQ15 - reset open at power-up: reset input fault
// RQ16 - response time is a build parameter
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module lco_ctrl
  import lco_pkg::*;
#(
  parameter int unsigned RST_OPEN_CYCLES = RST_OPEN_CYC,
  parameter int unsigned FLASH_CYCLES = FLASH_CYC,
  parameter int unsigned RESP_NS = RESP_TIME_NS
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic beam_top_clear,
  input wire logic beam_bottom_clear,
  input wire logic fault_detect,
  input wire logic reset_switch_closed,
  input wire logic power_good,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [1:0] safety_switching_outputs,
  output logic led_red_blocked,
  output logic led_green_clear,
  output logic led_align_top,
  output logic led_align_bottom,
  output logic scan_enable,
  output logic irq
);
  localparam int CNT_W = $clog2(RST_OPEN_CYCLES + 1);
  localparam int FL_W = $clog2(FLASH_CYCLES + 1);
  localparam int RESP_CYCLES = RESP_NS / CLK_PERIOD_NS;

  // turn-off takes one cycle, so any response of one cycle or more serves
  if (RESP_CYCLES < 1) begin : g_chk_resp
    $error("response time shorter than one clock"); // RQ16
  end
  if (RST_OPEN_CYCLES < 1 || FLASH_CYCLES < 1) begin : g_chk_cnt
    $error("reset and flash counts must be at least one");
  end

  lco_state_t st_q, st_d;
  logic latch_q;
  logic [NUM_EVT-1:0] int_sts_q, int_mask_q, evt;
  logic [CNT_W-1:0] open_cnt_q;
  logic [FL_W-1:0] flash_cnt_q;
  logic flash_q;
  logic safe_q;
  logic all_clear, open_done, rst_ok;

  assign all_clear = beam_top_clear & beam_bottom_clear;

  ////////////////////////////////////////////////////////////////////////
  // manual reset qualifier
  assign open_done = (open_cnt_q == CNT_W'(RST_OPEN_CYCLES));
  assign rst_ok = reset_switch_closed & open_done; // RQ7

  // a block during the open phase restarts the count, so the beams
  // must stay clear for the whole reset sequence
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_cnt_q <= '0;
    end else if (reset_switch_closed || !all_clear) begin // RQ5
      open_cnt_q <= '0;
    end else if (!open_done) begin // RQ7
      open_cnt_q <= open_cnt_q + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flash divider
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
    end else if (flash_cnt_q == FL_W'(FLASH_CYCLES - 1)) begin
      flash_cnt_q <= '0;
      flash_q <= ~flash_q;
    end else begin
      flash_cnt_q <= flash_cnt_q + FL_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operating state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_INIT: begin
        // switch level is sampled in the first cycle after release
        if (!reset_switch_closed) begin
          st_d = ST_RSTFLT; // RQ15
        end else if (fault_detect) begin
          st_d = ST_LOCKOUT; // RQ6
        end else if (latch_q) begin
          st_d = ST_WAIT; // RQ12 RQ14
        end else begin
          st_d = ST_BLOCKED;
        end
      end
      ST_RUN: begin
        if (fault_detect) begin
          st_d = ST_LOCKOUT; // RQ6
        end else if (!all_clear) begin
          st_d = ST_BLOCKED; // RQ1
        end
      end
      ST_BLOCKED: begin
        if (fault_detect) begin
          st_d = ST_LOCKOUT; // RQ6
        end else if (all_clear) begin
          st_d = latch_q ? ST_WAIT : ST_RUN; // RQ2 RQ3 RQ4
        end
      end
      ST_WAIT: begin
        if (fault_detect) begin
          st_d = ST_LOCKOUT; // RQ6
        end else if (all_clear && (rst_ok || !latch_q)) begin
          st_d = ST_RUN; // RQ5 RQ14
        end
      end
      ST_LOCKOUT: begin
        if (rst_ok) begin
          st_d = ST_INIT; // RQ14
        end
      end
      // leaves only through sys_rst; a drop of power_good does not leave it
      ST_RSTFLT: st_d = ST_RSTFLT; // RQ15
      default: st_d = ST_LOCKOUT;
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // safety outputs
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      safe_q <= 1'b0;
    end else begin
      safe_q <= (st_d == ST_RUN); // RQ1 RQ6
    end
  end

  // supply loss gates the outputs without waiting for a clock edge
  assign safety_switching_outputs = {2{safe_q & power_good}}; // RQ13

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scan_enable <= 1'b0;
    end else begin
      scan_enable <= (st_d != ST_LOCKOUT) && (st_d != ST_RSTFLT); // RQ6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // indicators
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led_red_blocked <= 1'b0;
      led_green_clear <= 1'b0;
      led_align_top <= 1'b0;
      led_align_bottom <= 1'b0;
    end else begin
      led_red_blocked <= 1'b0;
      led_green_clear <= 1'b0;
      led_align_top <= 1'b0;
      led_align_bottom <= 1'b0;
      unique case (st_q)
        ST_RUN: begin
          led_green_clear <= 1'b1; // RQ10
          led_align_top <= 1'b1;
          led_align_bottom <= 1'b1;
        end
        ST_BLOCKED: begin
          led_red_blocked <= 1'b1; // RQ9
          led_align_top <= beam_top_clear;
          led_align_bottom <= beam_bottom_clear;
        end
        ST_WAIT: begin
          led_red_blocked <= 1'b1; // RQ11
          led_align_top <= all_clear ? flash_q : beam_top_clear; // RQ4
          led_align_bottom <= all_clear ? flash_q : beam_bottom_clear;
        end
        ST_LOCKOUT: led_red_blocked <= flash_q; // RQ8
        ST_RSTFLT: begin
          led_red_blocked <= 1'b1; // RQ15
          led_green_clear <= 1'b1;
        end
        default: led_red_blocked <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events and interrupt
  assign evt[EVT_BLOCK] = (st_q == ST_RUN) && (st_d == ST_BLOCKED);
  assign evt[EVT_LOCK] = (st_q != ST_LOCKOUT) && (st_d == ST_LOCKOUT);
  assign evt[EVT_RESET] = rst_ok && (st_d != st_q);
  assign evt[EVT_RSTFLT] = (st_q != ST_RSTFLT) && (st_d == ST_RSTFLT);

  // a new event wins over a write-one-to-clear in the same cycle
  for (genvar i = 0; i < NUM_EVT; i++) begin : g_sts
    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        int_sts_q[i] <= 1'b0;
      end else if (evt[i]) begin
        int_sts_q[i] <= 1'b1;
      end else if (reg_wr && reg_addr == ADDR_INT_STS && reg_wdata[i]) begin
        int_sts_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(int_sts_q & int_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      latch_q <= CTRL_LATCH_RST;
      int_mask_q <= INT_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CTRL) begin
        latch_q <= reg_wdata[CTRL_LATCH_BIT];
      end
      if (reg_addr == ADDR_INT_MASK) begin
        int_mask_q <= reg_wdata[NUM_EVT-1:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CTRL: reg_rdata[CTRL_LATCH_BIT] <= latch_q;
          ADDR_STATE: begin
            reg_rdata[2:0] <= st_q;
            reg_rdata[STATE_ON_BIT] <= safe_q;
            reg_rdata[STATE_CLEAR_BIT] <= all_clear;
          end
          ADDR_INT_STS: reg_rdata[NUM_EVT-1:0] <= int_sts_q;
          ADDR_INT_MASK: reg_rdata[NUM_EVT-1:0] <= int_mask_q;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_clear_after_block;
    latch_q && st_q == ST_BLOCKED && all_clear && !fault_detect;
  endsequence
  sequence s_wait_pattern;
    st_q == ST_WAIT ##1 led_red_blocked && !led_green_clear;
  endsequence

  a_block_turnoff: assert property ( // RQ1
    st_q == ST_RUN && !all_clear |=> !safe_q)
    else $error("outputs stayed on while blocked");
  a_trip_recover: assert property ( // RQ2
    !latch_q && st_q == ST_BLOCKED && all_clear && !fault_detect
    |=> st_q == ST_RUN && safe_q)
    else $error("trip mode did not recover");
  a_trip_no_wait: assert property ( // RQ3
    !latch_q && st_q == ST_WAIT && all_clear && !fault_detect
    |=> st_q == ST_RUN)
    else $error("trip mode waited for a reset");
  a_latch_hold: assert property ( // RQ4
    s_clear_after_block |=> s_wait_pattern)
    else $error("latch mode did not hold off");
  a_latch_release: assert property ( // RQ5
    st_q == ST_WAIT && latch_q && st_d == ST_RUN |-> rst_ok && all_clear)
    else $error("latch released without valid reset");
  a_fault_lockout: assert property ( // RQ6
    fault_detect && (st_q inside {ST_RUN, ST_BLOCKED, ST_WAIT})
    |=> st_q == ST_LOCKOUT && !safe_q && !scan_enable)
    else $error("fault did not lock out");
  a_reset_length: assert property ( // RQ7
    $rose(open_done) |-> $past(!reset_switch_closed, 1))
    else $error("reset count advanced while closed");
  a_lock_flash: assert property ( // RQ8
    st_q == ST_LOCKOUT |=> led_red_blocked == $past(flash_q))
    else $error("lockout red not flashing");
  a_blocked_leds: assert property ( // RQ9
    st_q == ST_BLOCKED |=> led_red_blocked && !led_green_clear
    && led_align_top == $past(beam_top_clear))
    else $error("blocked indicators wrong");
  a_clear_leds: assert property ( // RQ10
    st_q == ST_RUN |=> led_green_clear && !led_red_blocked
    && led_align_top && led_align_bottom)
    else $error("clear indicators wrong");
  a_latched_leds: assert property ( // RQ11
    st_q == ST_WAIT && all_clear |=> led_align_top == $past(flash_q)
    && led_align_bottom == $past(flash_q) && led_red_blocked)
    else $error("latched indicators wrong");
  a_powerup_latch: assert property ( // RQ12
    st_q == ST_INIT && latch_q && reset_switch_closed && !fault_detect
    |=> st_q == ST_WAIT ##1 !safe_q)
    else $error("latch power-up did not wait");
  a_power_loss: assert property ( // RQ13
    !power_good |-> safety_switching_outputs == 2'b00)
    else $error("outputs on without power");
  a_rstflt_leds: assert property ( // RQ15
    st_q == ST_INIT && !reset_switch_closed |=> st_q == ST_RSTFLT
    ##1 led_red_blocked && led_green_clear && !led_align_top)
    else $error("reset input fault not shown");
endmodule : lco_ctrl

// >>> bench/lco_sw_model.sv
// manual reset switch model on the far side of the output control
// assumes one go pulse per gesture, launched by the bench on core_clk
`timescale 1ns/1ns
module lco_sw_model (
  input wire logic core_clk,
  input wire logic hold_open,
  input wire logic go,
  input wire logic [7:0] open_len,
  output logic switch_closed,
  output logic busy
);
  logic [7:0] cnt_q = 8'h00;
  always @(posedge core_clk) begin
    if (go) begin
      cnt_q <= open_len;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // open for open_len cycles, then closed again
  assign switch_closed = !hold_open && cnt_q == 8'h00;
  assign busy = cnt_q != 8'h00;
endmodule : lco_sw_model

// >>> bench/tb.sv
// self-checking bench of the light curtain output and latch control
// assumes lco_pkg, lco_ctrl and the reset switch model
`timescale 1ns/1ns
module tb;
  import lco_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic beam_t = 1'b1;
  logic beam_b = 1'b1;
  logic fault = 1'b0;
  logic pgood = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic go = 1'b0;
  logic hold = 1'b0;
  logic [7:0] olen = 8'h0a;
  logic sw_closed, sw_busy, red, green, at, ab, scan, irq;
  logic [31:0] reg_rdata;
  logic [1:0] outs;
  logic [2:0] f;
  logic [31:0] v = 32'd93701;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  always #4 core_clk = ~core_clk;

  lco_sw_model sw_u (.core_clk(core_clk), .hold_open(hold), .go(go),
    .open_len(olen), .switch_closed(sw_closed), .busy(sw_busy));

  // short counts keep the run brief
  lco_ctrl #(.RST_OPEN_CYCLES(8), .FLASH_CYCLES(4), .RESP_NS(8)) dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst), .beam_top_clear(beam_t),
    .beam_bottom_clear(beam_b), .fault_detect(fault),
    .reset_switch_closed(sw_closed), .power_good(pgood),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .safety_switching_outputs(outs), .led_red_blocked(red),
    .led_green_clear(green), .led_align_top(at),
    .led_align_bottom(ab), .scan_enable(scan), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] sw(input logic [2:0] c, input logic on,
    input logic clr);
    return {27'h0, clr, on, c};
  endfunction : sw
  function automatic logic [1:0] exp_out(input logic [1:0] b);
    return (b == 2'b11) ? 2'b11 : 2'b00;
  endfunction : exp_out

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask : rd
  task automatic gesture(input logic [7:0] n);
    @(posedge core_clk);
    olen <= n;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
  endtask : gesture
  // which of red, top, bottom toggled within a flash period and a half
  task automatic flashing(output logic [2:0] t);
    logic [2:0] hi, lo;
    hi = 3'b000;
    lo = 3'b000;
    repeat (12) begin
      cyc(1);
      hi = hi | {red, at, ab};
      lo = lo | ~{red, at, ab};
    end
    t = hi & lo;
  endtask : flashing

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(4);
    rd(ADDR_STATE, sw(3'b001, 1'b1, 1'b1));
    chk(outs, 2'b11);
    chk({red, green, at, ab}, 4'b0111);
    @(posedge core_clk);
    beam_t <= 1'b0;
    cyc(2);
    chk(outs, 2'b00);
    chk({red, green, at, ab}, 4'b1001);
    chk(irq, 1'b0);
    wr(ADDR_INT_MASK, 32'h1);
    cyc(1);
    chk(irq, 1'b1);
    wr(ADDR_INT_STS, 32'h1);
    cyc(1);
    chk(irq, 1'b0);
    @(posedge core_clk);
    beam_t <= 1'b1;
    cyc(3);
    chk(outs, 2'b11);
    @(posedge core_clk);
    pgood <= 1'b0;
    #1;
    chk(outs, 2'b00);
    @(posedge core_clk);
    pgood <= 1'b1;
    cyc(2);
    chk(outs, 2'b11);
    repeat (20) begin
      v = lfsr(v);
      @(posedge core_clk);
      beam_t <= v[0];
      beam_b <= v[1];
      cyc(3);
      chk(outs, exp_out(v[1:0]));
    end
    @(posedge core_clk);
    beam_t <= 1'b1;
    beam_b <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    @(posedge core_clk);
    beam_b <= 1'b0;
    cyc(3);
    @(posedge core_clk);
    beam_b <= 1'b1;
    cyc(3);
    rd(ADDR_STATE, sw(3'b010, 1'b0, 1'b1));
    chk(outs, 2'b00);
    chk({red, green}, 2'b10);
    flashing(f);
    chk(f, 3'b011);
    gesture(8'h04);
    cyc(8);
    chk(outs, 2'b00);
    gesture(8'h0a);
    cyc(14);
    chk(outs, 2'b11);
    rd(ADDR_STATE, sw(3'b001, 1'b1, 1'b1));
    @(posedge core_clk);
    fault <= 1'b1;
    cyc(2);
    chk(outs, 2'b00);
    chk(scan, 1'b0);
    flashing(f);
    chk(f, 3'b100);
    @(posedge core_clk);
    fault <= 1'b0;
    rd(ADDR_STATE, sw(3'b110, 1'b0, 1'b1));
    gesture(8'h0a);
    cyc(16);
    rd(ADDR_STATE, sw(3'b010, 1'b0, 1'b1));
    chk(outs, 2'b00);
    rd(ADDR_INT_STS, 32'h7);
    // back to trip mode while waiting: no reset needed to run
    wr(ADDR_CTRL, 32'h0);
    cyc(2);
    chk(outs, 2'b11);
    @(posedge core_clk);
    hold <= 1'b1;
    sys_rst <= 1'b1;
    cyc(2);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    cyc(4);
    chk({red, green, at, ab}, 4'b1100);
    chk(scan, 1'b0);
    rd(ADDR_STATE, sw(3'b100, 1'b0, 1'b1));
    rd(ADDR_INT_STS, 32'h8);
    rd(4'h2, 32'h0);
    rd(ADDR_INT_MASK, 32'h0);
    end_of_test();
  end
endmodule : tb
